/* core/sts_pkg.sv */
package sts_pkg;

  // command opcodes handled here
  localparam logic [7:0] OP_TEST_READY = 8'h00;
  localparam logic [7:0] OP_REZERO     = 8'h01;
  localparam logic [7:0] OP_REQ_SENSE  = 8'h03;

  // status byte values
  localparam logic [7:0] ST_GOOD  = 8'h00;
  localparam logic [7:0] ST_CHECK = 8'h02;
  localparam logic [7:0] ST_BUSY  = 8'h08;
  localparam logic [7:0] ST_RESV  = 8'h18;

  // sense byte zero layout
  localparam int SB0_VALID_POS = 7;
  localparam int SB0_CLASS_LSB = 4;

  // error classes
  localparam logic [2:0] CLS_DRIVE   = 3'h0;
  localparam logic [2:0] CLS_RECOV   = 3'h1;
  localparam logic [2:0] CLS_REQUEST = 3'h2;
  localparam logic [2:0] CLS_EXTEND  = 3'h7;

  // drive-state codes
  localparam logic [7:0] EC_NO_SENSE   = 8'h00;
  localparam logic [7:0] EC_NO_INDEX   = 8'h01;
  localparam logic [7:0] EC_NO_SEEK    = 8'h02;
  localparam logic [7:0] EC_WR_FAULT   = 8'h03;
  localparam logic [7:0] EC_NOT_READY  = 8'h04;
  localparam logic [7:0] EC_SEL_FAIL   = 8'h05;
  // data-recovery codes
  localparam logic [7:0] EC_ID_CRC     = 8'h10;
  localparam logic [7:0] EC_UNCORR     = 8'h11;
  localparam logic [7:0] EC_NO_IDAM    = 8'h12;
  localparam logic [7:0] EC_NO_RECORD  = 8'h14;
  localparam logic [7:0] EC_SEEK_ERR   = 8'h15;
  localparam logic [7:0] EC_NORETRY    = 8'h18;
  localparam logic [7:0] EC_VERIFY_ECC = 8'h19;
  localparam logic [7:0] EC_BAD_FORMAT = 8'h1c;
  // host request codes
  localparam logic [7:0] EC_BAD_OPCODE = 8'h20;
  localparam logic [7:0] EC_BAD_LBA    = 8'h21;
  localparam logic [7:0] EC_VOL_OVFL   = 8'h23;
  localparam logic [7:0] EC_BAD_ARG    = 8'h24;
  localparam logic [7:0] EC_BAD_LUN    = 8'h25;
  localparam logic [7:0] EC_WR_PROT    = 8'h27;
  localparam logic [7:0] EC_CART_CHG   = 8'h28;
  localparam logic [7:0] EC_PARAM_MISM = 8'h29;
  localparam logic [7:0] EC_LIMIT_VIOL = 8'h2b;
  localparam logic [7:0] EC_ERR_COUNT  = 8'h2c;
  localparam logic [7:0] EC_INIT_ERR   = 8'h2d;
  localparam logic [7:0] EC_BUS_PARITY = 8'h2e;
  localparam logic [7:0] EC_HW_CHECK   = 8'h2f;

  // format progress code range
  localparam logic [7:0] PC_FIRST = 8'h10;
  localparam logic [7:0] PC_LAST  = 8'h16;

  // sense geometry
  localparam int          SENSE_BYTES = 4;
  localparam logic [7:0]  SENSE_LEN   = 8'h04;
  localparam int          LUN_MAX     = 3;
  localparam int          LBA_SHORT   = 21;
  localparam logic [31:0] LBA_MASK21  = 32'h001f_ffff;

  // rezero timeout in us, and cycles at 20 MHz
  localparam int REZERO_TMO_US = 1000;
  localparam int CLK_MHZ       = 20;
  localparam int REZERO_CYC    = REZERO_TMO_US * CLK_MHZ;

  // one received command
  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] lun;
    logic [2:0] host;
    logic [7:0] alloc_len;
    logic       reserved_bad;
  } sts_cmd_t;

  // one posted error
  typedef struct packed {
    logic [7:0]  code;
    logic        lba_valid;
    logic [31:0] lba;
    logic [7:0]  progress;
    logic [7:0]  sectors;
    logic [7:0]  inner_code;
  } sts_err_t;

  // one unit's pending sense
  typedef struct packed {
    logic       pending;
    logic [2:0] owner;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] b3;
  } sts_sense_t;

endpackage

/* core/sts_sense_fmt.sv */
`timescale 1ns/1ps
`default_nettype none
// packs a posted error into the four sense bytes
module sts_sense_fmt (
  input  wire sts_pkg::sts_err_t   err_i,     // error to encode
  input  wire logic                wide_i,    // 24-bit address format
  output var sts_pkg::sts_sense_t  sense_o    // packed bytes, pending=1
);

  logic [2:0]  cls;
  logic [31:0] lba;
  logic        fmt_err;

  // class comes from the code's upper nibble
  always_comb begin
    case (err_i.code[7:4])
      4'h0:    cls = sts_pkg::CLS_DRIVE;
      4'h1:    cls = sts_pkg::CLS_RECOV;
      4'h2:    cls = sts_pkg::CLS_REQUEST;
      default: cls = sts_pkg::CLS_EXTEND;
    endcase
  end

  // narrow format keeps only 21 bits; reserved bits of byte one stay zero
  assign lba = wide_i ? err_i.lba : (err_i.lba & sts_pkg::LBA_MASK21);
  assign fmt_err = (err_i.code == sts_pkg::EC_BAD_FORMAT);

  // bad format replaces the address with diagnostics, flag kept clear
  always_comb begin
    sense_o.pending = 1'b1;
    sense_o.owner   = 3'h0;
    sense_o.b0      = {err_i.lba_valid & ~fmt_err, cls,
                       err_i.code[3:0]};
    if (fmt_err) begin
      sense_o.b1 = err_i.progress;
      sense_o.b2 = err_i.sectors;
      sense_o.b3 = err_i.inner_code;
    end else if (err_i.lba_valid) begin
      // three bytes hold the low 24 bits; a wider address loses its top
      sense_o.b1 = wide_i ? lba[23:16] : {3'h0, lba[20:16]};
      sense_o.b2 = lba[15:8];
      sense_o.b3 = lba[7:0];
    end else begin
      sense_o.b1 = 8'h00;
      sense_o.b2 = 8'h00;
      sense_o.b3 = 8'h00;
    end
  end

endmodule
`default_nettype wire

/* core/sts_target.sv */
`timescale 1ns/1ps
`default_nettype none
module sts_target #(
  parameter int LUNS       = 4,                    // logical units served
  parameter int REZERO_CYC = sts_pkg::REZERO_CYC   // rezero timeout cycles
) (
  input  wire logic              sys_clk_i,        // 20 MHz clock
  input  wire logic              arst_n_i,         // async reset, low
  input  wire logic              cmd_valid_i,      // command strobe
  input  wire sts_pkg::sts_cmd_t cmd_i,            // command fields
  input  wire logic [LUNS-1:0]   unit_ready_i,     // unit powered and ready
  input  wire logic [LUNS-1:0]   unit_busy_i,      // unit busy
  input  wire logic [LUNS-1:0]   unit_fault_i,     // write fault seen
  input  wire logic [LUNS-1:0]   unit_sel_fail_i,  // select failure seen
  input  wire logic [LUNS-1:0]   unit_rsv_i,       // reserved elsewhere
  input  wire logic [2:0]        rsv_host_i,       // reserving host
  input  wire logic              wide_lba_i,       // 24-bit sense format
  input  wire logic              track0_i,         // drive at track zero
  input  wire logic              err_valid_i,      // other logic posts error
  input  wire logic [2:0]        err_lun_i,        // unit of posted error
  input  wire logic [2:0]        err_host_i,       // host of posted error
  input  wire sts_pkg::sts_err_t err_i,            // posted error
  output logic                   seek_zero_o,      // drive seek request
  output logic                   done_o,           // status valid pulse
  output logic [7:0]             status_o,         // status byte
  output logic                   data_valid_o,     // sense byte strobe
  output logic [7:0]             data_o,           // sense byte
  output logic [LUNS-1:0]        pending_o         // unit holds sense
);

  // elaboration checks: the unit index is two bits wide
  if (LUNS < 1 || LUNS > sts_pkg::LUN_MAX + 1) begin : g_bad_luns
    $error("LUNS must be 1..4");
  end
  if (REZERO_CYC < 1) begin : g_bad_tmo
    $error("REZERO_CYC must be positive");
  end

  typedef enum {S_IDLE, S_SEEK, S_SEND, S_STATUS} sts_state_t;

  sts_state_t         state;
  sts_pkg::sts_sense_t sense [LUNS];
  sts_pkg::sts_cmd_t  cur;
  logic [1:0]         byte_idx;
  logic [31:0]        tmo;
  logic [7:0]         next_status;
  logic               post_own;
  sts_pkg::sts_err_t  own_err;
  sts_pkg::sts_err_t  sel_err;
  logic [2:0]         sel_lun;
  logic [2:0]         sel_host;
  logic               sel_post;
  sts_pkg::sts_sense_t fmt_sense;
  logic               lun_ok;
  logic [1:0]         lun;
  logic               foreign;
  logic               tmo_hit;

  assign lun_ok  = (cmd_i.lun <= 3'(LUNS - 1));
  assign lun     = cmd_i.lun[1:0];
  assign foreign = lun_ok && sense[lun].pending
                   && sense[lun].owner != cmd_i.host;
  assign tmo_hit = (tmo == 32'(REZERO_CYC - 1));

  // status and sense source decided at command acceptance
  always_comb begin
    next_status = sts_pkg::ST_GOOD;
    post_own    = 1'b0;
    own_err     = '0;
    if (!lun_ok) begin
      post_own     = 1'b1;
      own_err.code = sts_pkg::EC_BAD_LUN;
    end else if (cmd_i.reserved_bad) begin
      post_own     = 1'b1;
      own_err.code = sts_pkg::EC_BAD_ARG;
    end else if (cmd_i.opcode == sts_pkg::OP_TEST_READY) begin
      if (unit_rsv_i[lun] && rsv_host_i != cmd_i.host) begin
        next_status = sts_pkg::ST_RESV;
      end else if (unit_busy_i[lun]) begin
        next_status = sts_pkg::ST_BUSY;
      end else if (unit_sel_fail_i[lun]) begin
        post_own     = 1'b1;
        own_err.code = sts_pkg::EC_SEL_FAIL;
      end else if (unit_fault_i[lun]) begin
        post_own     = 1'b1;
        own_err.code = sts_pkg::EC_WR_FAULT;
      end else if (!unit_ready_i[lun]) begin
        post_own     = 1'b1;
        own_err.code = sts_pkg::EC_NOT_READY;
      end else begin
        next_status = sts_pkg::ST_GOOD;
      end
    end else if (cmd_i.opcode != sts_pkg::OP_REZERO &&
                 cmd_i.opcode != sts_pkg::OP_REQ_SENSE) begin
      post_own     = 1'b1;
      own_err.code = sts_pkg::EC_BAD_OPCODE;
    end
    if (post_own)
      next_status = sts_pkg::ST_CHECK;
  end

  // sense writes come from the accepted command first, then the rezero timeout, else from the posting port
  always_comb begin
    sel_post = 1'b0;
    sel_err  = err_i;
    sel_lun  = err_lun_i;
    sel_host = err_host_i;
    if (state == S_IDLE && cmd_valid_i && !foreign && post_own && lun_ok) begin
      sel_post = 1'b1;
      sel_err  = own_err;
      sel_lun  = cmd_i.lun;
      sel_host = cmd_i.host;
    end else if (state == S_SEEK && tmo_hit && !track0_i) begin
      sel_post     = 1'b1;
      sel_err      = '0;
      sel_err.code = sts_pkg::EC_NO_SEEK;
      sel_lun      = cur.lun;
      sel_host     = cur.host;
    end else if (err_valid_i && err_lun_i <= 3'(LUNS - 1)) begin
      sel_post = 1'b1;
    end
  end

  sts_sense_fmt u_fmt (
    .err_i   (sel_err),
    .wide_i  (wide_lba_i),
    .sense_o (fmt_sense)
  );

  // per-unit sense store: posting sets, same-host command clears
  // a post in the same cycle as a clear wins, so that clear does not drop the fresh sense
  generate
    for (genvar u = 0; u < LUNS; u++) begin : g_unit
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          sense[u] <= '0;
        end else if (sel_post && sel_lun == 3'(u)) begin
          sense[u]       <= fmt_sense;
          sense[u].owner <= sel_host;
        end else if (state == S_SEND && byte_idx == 2'd3 &&
                     cur.lun == 3'(u)) begin
          sense[u].pending <= 1'b0;
        end else if (state == S_IDLE && cmd_valid_i && lun_ok &&
                     lun == 2'(u) && sense[u].owner == cmd_i.host &&
                     cmd_i.opcode != sts_pkg::OP_REQ_SENSE) begin
          sense[u].pending <= 1'b0;
        end
      end
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i)
          pending_o[u] <= 1'b0;
        else
          pending_o[u] <= sense[u].pending;
      end
    end
  endgenerate

  // command latch: the byte stream and the no-seek error need it later
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cur <= '0;
    end else if (state == S_IDLE && cmd_valid_i) begin
      cur <= cmd_i;
    end
  end

  // seek timeout counter, held at zero outside the seek state
  // a head that never reports track zero must not hang the target
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tmo <= 32'h0000_0000;
    end else if (state == S_SEEK) begin
      tmo <= tmo + 32'h0000_0001;
    end else begin
      tmo <= 32'h0000_0000;
    end
  end

  // sense byte index; four bytes regardless of allocation length
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      byte_idx <= 2'd0;
    end else if (state == S_SEND) begin
      byte_idx <= byte_idx + 2'd1;
    end else begin
      byte_idx <= 2'd0;
    end
  end

  // seek request stands from acceptance until track zero or timeout
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seek_zero_o <= 1'b0;
    end else if (state == S_IDLE && cmd_valid_i && !foreign && !post_own &&
                 cmd_i.opcode == sts_pkg::OP_REZERO) begin
      seek_zero_o <= 1'b1;
    end else if (state == S_SEEK && (track0_i || tmo_hit)) begin
      seek_zero_o <= 1'b0;
    end
  end

  // command sequencer: state, status byte and done pulse
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= S_IDLE;
      done_o   <= 1'b0;
      status_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      case (state)
        S_IDLE: begin
          if (cmd_valid_i) begin
            if (foreign) begin
              status_o <= sts_pkg::ST_BUSY;
              done_o   <= 1'b1;
            end else if (!post_own &&
                         cmd_i.opcode == sts_pkg::OP_REZERO) begin
              state <= S_SEEK;
            end else if (!post_own &&
                         cmd_i.opcode == sts_pkg::OP_REQ_SENSE) begin
              state <= S_SEND;
            end else begin
              status_o <= next_status;
              done_o   <= 1'b1;
            end
          end
        end
        // completion waits for track zero; timeout posts no-seek
        S_SEEK: begin
          if (track0_i || tmo_hit) begin
            status_o <= track0_i ? sts_pkg::ST_GOOD
                                 : sts_pkg::ST_CHECK;
            done_o   <= 1'b1;
            state    <= S_IDLE;
          end
        end
        // the last of the four bytes hands over to status
        S_SEND: begin
          if (byte_idx == 2'd3)
            state <= S_STATUS;
        end
        // request sense itself ends good; faults travel in the bytes
        S_STATUS: begin
          status_o <= sts_pkg::ST_GOOD;
          done_o   <= 1'b1;
          state    <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // one strobe per sense byte
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_valid_o <= 1'b0;
    end else begin
      data_valid_o <= (state == S_SEND);
    end
  end

  // sense byte stream, a plain zero record when nothing is pending
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= 8'h00;
    end else if (state != S_SEND || !sense[cur.lun[1:0]].pending) begin
      data_o <= 8'h00;
    end else begin
      case (byte_idx)
        2'd0:    data_o <= sense[cur.lun[1:0]].b0;
        2'd1:    data_o <= sense[cur.lun[1:0]].b1;
        2'd2:    data_o <= sense[cur.lun[1:0]].b2;
        default: data_o <= sense[cur.lun[1:0]].b3;
      endcase
    end
  end

endmodule
`default_nettype wire

/* dv/sts_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
// head positioner behind the target: reaches track zero lat_i + 1 cycles
// after a seek request, or never when stuck
module sts_drive_model (
  input  wire logic       sys_clk_i,    // clock
  input  wire logic       arst_n_i,     // async reset, low
  input  wire logic       seek_zero_i,  // seek request
  input  wire logic [4:0] lat_i,        // travel time in cycles
  input  wire logic       stuck_i,      // head never arrives
  output logic            track0_o      // head at track zero
);
  logic [4:0] cnt;

  // travel time restarts with every request
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= 5'h00;
    end else if (!seek_zero_i) begin
      cnt <= 5'h00;
    end else if (cnt != 5'h1f) begin
      cnt <= cnt + 5'h01;
    end
  end

  // head leaves zero once released, so every rezero really travels
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      track0_o <= 1'b0;
    end else begin
      track0_o <= seek_zero_i && !stuck_i && cnt >= lat_i;
    end
  end
endmodule
`default_nettype wire

/* dv/sts_target_properties.sv */
`timescale 1ns/1ps
`default_nettype none
// port checks for the target; one clock domain
module sts_target_properties #(
  parameter int LUNS = 4  // logical units served
) (
  input wire logic              sys_clk_i,       // clock
  input wire logic              arst_n_i,        // reset, low
  input wire logic              cmd_valid_i,     // command strobe
  input wire sts_pkg::sts_cmd_t cmd_i,           // command fields
  input wire logic [LUNS-1:0]   unit_ready_i,    // unit ready
  input wire logic [LUNS-1:0]   unit_busy_i,     // unit busy
  input wire logic [LUNS-1:0]   unit_fault_i,    // write fault
  input wire logic [LUNS-1:0]   unit_sel_fail_i, // select failure
  input wire logic [LUNS-1:0]   unit_rsv_i,      // reserved
  input wire logic              track0_i,        // at track zero
  input wire logic              err_valid_i,     // error posted
  input wire logic [2:0]        err_host_i,      // its host
  input wire logic              seek_zero_o,     // seek request
  input wire logic              done_o,          // status pulse
  input wire logic [7:0]        status_o,        // status byte
  input wire logic              data_valid_o,    // sense strobe
  input wire logic [LUNS-1:0]   pending_o        // sense held
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  logic       open_q;   // command between take and done
  logic [2:0] lun_q;    // unit of last taken command
  logic [2:0] host_q;   // host of last taken command
  logic [2:0] owner_q;  // host owed the pending sense
  logic [2:0] u;        // addressed unit
  logic       take;     // command accepted at this edge
  logic       own;      // sender is the sense owner
  logic       tr;       // test ready, unit exists, no sense held

  // a command is taken whenever the target is idle, done edge included
  assign u = cmd_i.lun;
  assign take = cmd_valid_i && (!open_q || done_o);
  assign own = cmd_i.host == owner_q;
  assign tr = take && int'(u) < LUNS && !pending_o[u] && !cmd_i.reserved_bad
              && cmd_i.opcode == sts_pkg::OP_TEST_READY;

  // posted errors never open the window
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      open_q <= 1'b0;
    end else if (take) begin
      open_q <= 1'b1;
    end else if (done_o) begin
      open_q <= 1'b0;
    end
  end

  // the host that saw the check is the only one allowed to collect it
  always_ff @(posedge sys_clk_i) begin
    if (take) begin
      lun_q <= u;
      host_q <= cmd_i.host;
    end
    if (err_valid_i) begin
      owner_q <= err_host_i;
    end else if (done_o && status_o == sts_pkg::ST_CHECK
                 && int'(lun_q) < LUNS) begin
      owner_q <= host_q;
    end
  end

  sequence s_four_bytes;
    data_valid_o [*4] ##1 (done_o && !data_valid_o);
  endsequence
  sequence s_status(logic [7:0] v);
    done_o && status_o == v;
  endsequence

  property p_ready_good;
    tr && unit_ready_i[u] && !unit_fault_i[u] && !unit_sel_fail_i[u]
    && !unit_busy_i[u] && !unit_rsv_i[u] |=> s_status(sts_pkg::ST_GOOD);
  endproperty
  property p_busy;
    tr && unit_ready_i[u] && unit_busy_i[u] && !unit_fault_i[u]
    && !unit_sel_fail_i[u] && !unit_rsv_i[u] |=> s_status(sts_pkg::ST_BUSY);
  endproperty
  property p_check;
    tr && !unit_ready_i[u] && !unit_busy_i[u] && !unit_rsv_i[u]
    |=> s_status(sts_pkg::ST_CHECK) ##[0:2] pending_o[lun_q];
  endproperty
  property p_sense;
    take && cmd_i.opcode == sts_pkg::OP_REQ_SENSE && int'(u) < LUNS
    && !cmd_i.reserved_bad && (!pending_o[u] || own)
    |=> !data_valid_o ##1 s_four_bytes;
  endproperty
  property p_foreign;
    take && int'(u) < LUNS && pending_o[u] && !own
    |=> s_status(sts_pkg::ST_BUSY) && !data_valid_o;
  endproperty
  property p_clear;
    take && cmd_i.opcode == sts_pkg::OP_REQ_SENSE && int'(u) < LUNS
    && !cmd_i.reserved_bad && pending_o[u] && own
    |=> ##[1:7] !pending_o[lun_q];
  endproperty
  property p_rezero_wait;
    seek_zero_o && !track0_i |-> !(done_o && status_o == sts_pkg::ST_GOOD);
  endproperty
  property p_rezero_done;
    seek_zero_o && track0_i |-> ##[1:2] s_status(sts_pkg::ST_GOOD);
  endproperty

  a_ready_good: assert property (p_ready_good) else $error("no good");
  a_busy: assert property (p_busy) else $error("no busy status");
  a_check: assert property (p_check) else $error("no check kept");
  a_sense: assert property (p_sense) else $error("not four bytes");
  a_foreign: assert property (p_foreign) else $error("foreign host");
  a_clear: assert property (p_clear) else $error("sense not cleared");
  a_rezero_wait: assert property (p_rezero_wait) else $error("early");
  a_rezero_done: assert property (p_rezero_done) else $error("late");
endmodule

bind sts_target sts_target_properties #(.LUNS(LUNS)) i_sts_target_properties (
  .sys_clk_i, .arst_n_i, .cmd_valid_i, .cmd_i, .unit_ready_i, .unit_busy_i,
  .unit_fault_i, .unit_sel_fail_i, .unit_rsv_i, .track0_i, .err_valid_i,
  .err_host_i, .seek_zero_o, .done_o, .status_o, .data_valid_o, .pending_o);
`default_nettype wire

/* dv/test_sts_target.sv */
`timescale 1ns/1ps
`default_nettype none
// command sequences against the target with expected replies
module test_sts_target;
  localparam int LUNS = 4;
  logic sys_clk_i, arst_n_i, cmd_valid_i, err_valid_i, wide_lba_i;
  logic track0_i, seek_zero_o, done_o, data_valid_o, stuck, bad_arg;
  logic [LUNS-1:0] unit_ready_i, unit_busy_i, unit_fault_i;
  logic [LUNS-1:0] unit_sel_fail_i, unit_rsv_i, pending_o;
  logic [2:0] rsv_host_i, err_lun_i, err_host_i;
  logic [7:0] status_o, data_o, st;
  logic [7:0] sb [4];
  logic [7:0] fc [3] = '{8'h04, 8'h03, 8'h05};
  logic [7:0] pc [8] = '{8'h01, 8'h10, 8'h11, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f};
  logic [4:0] lat;
  sts_pkg::sts_cmd_t cmd_i;
  sts_pkg::sts_err_t err_i;
  int mismatches, checks, nb;

  sts_target #(.LUNS(LUNS), .REZERO_CYC(20)) i_sts_target (
    .sys_clk_i, .arst_n_i, .cmd_valid_i, .cmd_i, .unit_ready_i, .unit_busy_i,
    .unit_fault_i, .unit_sel_fail_i, .unit_rsv_i, .rsv_host_i, .wide_lba_i,
    .track0_i, .err_valid_i, .err_lun_i, .err_host_i, .err_i, .seek_zero_o,
    .done_o, .status_o, .data_valid_o, .data_o, .pending_o);
  sts_drive_model i_sts_drive_model (.sys_clk_i, .arst_n_i,
    .seek_zero_i(seek_zero_o), .lat_i(lat), .stuck_i(stuck),
    .track0_o(track0_i));

  // 20 MHz
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("%0d comparisons, %0d mismatches", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one command, zero allocation length; collects bytes and status
  // outputs are read 1 ns after each edge, once they have settled
  task automatic run(input logic [7:0] op, input logic [2:0] lun,
                     input logic [2:0] host);
    int n;
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op, lun, host, 8'h00, bad_arg};
    @(posedge sys_clk_i);
    cmd_valid_i <= 1'b0;
    nb = 0;
    #1;
    for (n = 0; n < 60 && done_o !== 1'b1; n++) begin
      if (data_valid_o === 1'b1) begin
        if (nb < 4) sb[nb] = data_o;
        nb++;
      end
      @(posedge sys_clk_i);
      #1;
    end
    st = status_o;
    if (done_o !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask

  // request sense, comparing the first k bytes
  task automatic sense(input logic [2:0] lun, input logic [2:0] host,
                       input logic [31:0] exp, input int k);
    run(sts_pkg::OP_REQ_SENSE, lun, host);
    chk(8'(nb), sts_pkg::SENSE_LEN);
    chk(st, sts_pkg::ST_GOOD);
    for (int i = 0; i < k; i++) chk(sb[i], exp[31-8*i -: 8]);
  endtask

  // pending flags lag the status by a cycle
  task automatic pend(input logic [LUNS-1:0] exp);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk(8'(pending_o), 8'(exp));
  endtask

  // error raised by neighbouring logic for unit 0, host 1
  task automatic post(input logic [7:0] code, input logic v,
                      input logic [31:0] lba, input logic [23:0] x);
    @(posedge sys_clk_i);
    err_valid_i <= 1'b1;
    err_i <= '{code, v, lba, x[23:16], x[15:8], x[7:0]};
    @(posedge sys_clk_i);
    err_valid_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask

  initial begin
    {arst_n_i, cmd_valid_i, err_valid_i, wide_lba_i, stuck, bad_arg} = '0;
    {unit_busy_i, unit_fault_i, unit_sel_fail_i, unit_rsv_i} = '0;
    {rsv_host_i, err_host_i, cmd_i} = '0;
    err_lun_i = 3'h0;
    err_host_i = 3'h1;
    err_i = '0;
    unit_ready_i = '1;
    lat = 5'h05;
    mismatches = 0;
    checks = 0;
    repeat (10) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    chk(status_o, 8'h00);
    // plain unit, busy unit, unit reserved by another host
    run(sts_pkg::OP_TEST_READY, 3'h0, 3'h1);
    chk(st, sts_pkg::ST_GOOD);
    sense(3'h0, 3'h1, 32'h0, 4);
    @(posedge sys_clk_i);
    unit_busy_i <= 4'h2;
    unit_rsv_i <= 4'h4;
    rsv_host_i <= 3'h5;
    run(sts_pkg::OP_TEST_READY, 3'h1, 3'h1);
    chk(st, sts_pkg::ST_BUSY);
    run(sts_pkg::OP_TEST_READY, 3'h2, 3'h1);
    chk(st, sts_pkg::ST_RESV);
    $display("test status finished");
    // not ready, write fault, select failure on unit 3
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk_i);
      unit_ready_i <= {k != 0, 3'h7};
      unit_fault_i <= {k == 1, 3'h0};
      unit_sel_fail_i <= {k == 2, 3'h0};
      run(sts_pkg::OP_TEST_READY, 3'h3, 3'h2);
      chk(st, sts_pkg::ST_CHECK);
      pend(4'h8);
      run(sts_pkg::OP_TEST_READY, 3'h3, 3'h4);
      chk(st, sts_pkg::ST_BUSY);
      sense(3'h3, 3'h2, {fc[k], 24'h0}, 1);
      pend(4'h0);
    end
    $display("test drive faults finished");
    // unit out of range, unknown opcode
    run(sts_pkg::OP_TEST_READY, 3'h5, 3'h1);
    chk(st, sts_pkg::ST_CHECK);
    run(8'h08, 3'h0, 3'h1);
    chk(st, sts_pkg::ST_CHECK);
    sense(3'h0, 3'h1, {sts_pkg::EC_BAD_OPCODE, 24'h0}, 1);
    // reserved bit set in the command block
    bad_arg = 1'b1;
    run(sts_pkg::OP_TEST_READY, 3'h0, 3'h1);
    chk(st, sts_pkg::ST_CHECK);
    bad_arg = 1'b0;
    sense(3'h0, 3'h1, {sts_pkg::EC_BAD_ARG, 24'h0}, 1);
    // rezero fast, slow and with a head that never arrives
    run(sts_pkg::OP_REZERO, 3'h0, 3'h1);
    chk(st, sts_pkg::ST_GOOD);
    lat <= 5'h0e;
    run(sts_pkg::OP_REZERO, 3'h0, 3'h1);
    chk(st, sts_pkg::ST_GOOD);
    stuck <= 1'b1;
    run(sts_pkg::OP_REZERO, 3'h0, 3'h1);
    chk(st, sts_pkg::ST_CHECK);
    sense(3'h0, 3'h1, {sts_pkg::EC_NO_SEEK, 24'h0}, 1);
    $display("test rezero finished");
    // posted codes of the drive, recovery and request classes
    for (int k = 0; k < 8; k++) begin
      post(pc[k], 1'b0, 32'h0, 24'h0);
      sense(3'h0, 3'h1, {pc[k], 24'h0}, 1);
    end
    // failing address in both formats
    post(8'h11, 1'b1, 32'h00ff_1234, 24'h0);
    sense(3'h0, 3'h1, 32'h911f_1234, 4);
    @(posedge sys_clk_i);
    wide_lba_i <= 1'b1;
    post(8'h11, 1'b1, 32'h00ff_1234, 24'h0);
    sense(3'h0, 3'h1, 32'h91ff_1234, 4);
    // bad format at both ends of the progress range
    for (int k = 0; k < 2; k++) begin
      post(8'h1c, 1'b1, 32'h0, {8'h10 + 8'(6 * k), 16'h0704});
      sense(3'h0, 3'h1, {8'h1c, 8'h10 + 8'(6 * k), 16'h0704}, 4);
    end
    $display("test sense layout finished");
    end_sim();
  end
endmodule
`default_nettype wire
